// *** core/edge_ctl_map.svh ***
// register map, field positions, reset values and codes of the edge control block
// assumes inclusion by bare name from the design files
`ifndef EDGE_CTL_MAP_SVH
`define EDGE_CTL_MAP_SVH
// byte addresses on the register bus
`define ADDR_MAIN_CONTROL 4'h0
`define ADDR_EDGE_CONFIG 4'h4
`define ADDR_CURRENT_CTRL 4'h8
`define ADDR_IRQ 4'hC
// main control fields
`define MC_MODULE_EN 7
`define MC_IDLE_STOP 5
`define MC_DELAY_MODE 4
`define MC_EDGE_PASS 3
`define MC_ORDERED 2
`define MC_DISCHARGE 1
`define MC_TRIG_EN 0
`define MC_WRITE_MASK 8'hBF
// edge config fields
`define EC_CH2_POL 7
`define EC_CH2_SEL_HI 6
`define EC_CH2_SEL_LO 5
`define EC_CH1_POL 4
`define EC_CH1_SEL_HI 3
`define EC_CH1_SEL_LO 2
`define EC_CH2_FLAG 1
`define EC_CH1_FLAG 0
// current control fields
`define CC_RANGE_HI 1
`define CC_RANGE_LO 0
`define CC_TRIM_HI 7
`define CC_TRIM_LO 2
// irq register fields
`define IRQ_FLAG_BIT 0
`define IRQ_EN_BIT 1
// source select codes
`define SRC_PIN_A 2'h3
`define SRC_PIN_B 2'h2
`define SRC_CMP_A 2'h1
`define SRC_CMP_B 2'h0
// reset values
`define RST_BYTE 8'h00
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/edge_ctl_pkg.sv ***
// types shared by the edge control block
// assumes the map header supplies all numbers
package edge_ctl_pkg;
  // edge configuration byte as packed fields
  typedef struct packed {
    logic ch2_pol;
    logic [1:0] ch2_sel;
    logic ch1_pol;
    logic [1:0] ch1_sel;
    logic ch2_flag;
    logic ch1_flag;
  } edge_cfg_t;
  // analog side controls travel together
  typedef struct packed {
    logic [1:0] range;
    logic [5:0] trim;
    logic gate;
    logic discharge;
    logic delay_mode;
  } analog_ctl_t;
  // bus slave write states
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage : edge_ctl_pkg

// *** core/edge_sync2.sv ***
// two flip-flop synchroniser for a vector of level inputs
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module edge_sync2 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // first stage, read only by second stage

  // two stages, nothing taps the first
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : edge_sync2

// *** core/edge_ctl.sv ***
// digital control of a charge/time measurement unit with axi4-lite registers
// assumes analog source, converter and comparator sit outside on plain pins
//
// Summary of operation
// - per channel polarity bit, 1 means high
// - two-bit source select per channel
// - channels respond to level, not transitions
// - hardware sets channel flag on response
// - config matching input sets flag at once
// - gate on when exactly one flag set
// - software may write both flags
// - ordered mode ignores channel 2 until 1
// - interrupt flag on gate on then off
// - range field drives current source
// - six-bit signed trim field to analog
// - edge pass bit clear blocks all edges
// - conversion trigger pulse after second event
// - discharge bit drives discharge output
// - mode bit selects measure or delay
// - reset defaults: negative, unordered, no trigger
// - delay mode ends pulse on comparator
// - module enable gates edge responses, gate and trigger
// - idle stop halts block in idle
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "edge_ctl_map.svh"
module edge_ctl (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // edge sources, asynchronous
  input wire logic ext_edge_pin_a_in,
  input wire logic ext_edge_pin_b_in,
  input wire logic compare_unit_a_in,
  input wire logic compare_unit_b_in,
  // chip state and comparator, asynchronous
  input wire logic chip_idle_in,
  input wire logic comparator_trip_in,
  // analog side
  output edge_ctl_pkg::analog_ctl_t analog_out,
  output logic conv_trigger_out,
  output logic irq_out
);
  // registers
  logic [7:0] main_ctl_q; // module and edge controls
  edge_ctl_pkg::edge_cfg_t cfg_q; // sources, polarities, flags
  logic [7:0] cur_ctl_q; // trim and range
  logic irq_flag_q; // sticky on-off cycle flag
  logic irq_en_q; // interrupt enable
  edge_ctl_pkg::wr_state_t wr_st_q;
  logic aw_held_q; // write address taken
  logic w_held_q; // write data taken
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic gate_prev_q; // previous gate for on-off detection
  logic both_prev_q; // previous both-flags state for trigger

  // synchronised inputs
  logic [5:0] sync_w;
  logic pin_a_s, pin_b_s, cmp_a_s, cmp_b_s, idle_s, trip_s;

  edge_sync2 #(.W(6)) u_sync (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in({comparator_trip_in, chip_idle_in, compare_unit_b_in,
               compare_unit_a_in, ext_edge_pin_b_in, ext_edge_pin_a_in}),
    .sync_out(sync_w)
  );
  assign {trip_s, idle_s, cmp_b_s, cmp_a_s, pin_b_s, pin_a_s} = sync_w;

  // source mux with polarity, used by both channels
  function automatic logic edge_level(input logic [1:0] sel, input logic pol,
                                      input logic pa, input logic pb,
                                      input logic ca, input logic cb);
    logic src;
    src = cb;
    if (sel == `SRC_PIN_A) src = pa;
    else if (sel == `SRC_PIN_B) src = pb;
    else if (sel == `SRC_CMP_A) src = ca;
    // polarity 1 = high level, 0 = low level
    edge_level = pol ? src : ~src;
  endfunction : edge_level

  // channel qualification
  logic running; // module on and not stopped by idle
  logic ch1_hit, ch2_hit;
  logic gate_now;
  assign running = main_ctl_q[`MC_MODULE_EN] &
                   ~(main_ctl_q[`MC_IDLE_STOP] & idle_s);
  assign ch1_hit = running & main_ctl_q[`MC_EDGE_PASS] &
                   edge_level(cfg_q.ch1_sel, cfg_q.ch1_pol,
                              pin_a_s, pin_b_s, cmp_a_s, cmp_b_s);
  // ordered mode holds channel 2 off until channel 1 flag stands
  assign ch2_hit = running & main_ctl_q[`MC_EDGE_PASS] &
                   (~main_ctl_q[`MC_ORDERED] | cfg_q.ch1_flag) &
                   edge_level(cfg_q.ch2_sel, cfg_q.ch2_pol,
                              pin_a_s, pin_b_s, cmp_a_s, cmp_b_s);
  assign gate_now = running & (cfg_q.ch1_flag ^ cfg_q.ch2_flag);

  // write decode helpers
  logic wr_fire;
  logic wr_ok;
  assign wr_fire = aw_held_q & w_held_q & (wr_st_q == edge_ctl_pkg::WR_IDLE);
  assign wr_ok = (aw_addr_q == `ADDR_MAIN_CONTROL) | (aw_addr_q == `ADDR_EDGE_CONFIG) |
                 (aw_addr_q == `ADDR_CURRENT_CTRL) | (aw_addr_q == `ADDR_IRQ);

  // address and data capture, either order
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end
    else
    begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      if (s_axi_awvalid_in & s_axi_awready_out)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      else if (!aw_held_q & s_axi_awvalid_in)
        s_axi_awready_out <= 1'b1; // one-cycle ready while address waits
      if (s_axi_wvalid_in & s_axi_wready_out)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      else if (!w_held_q & s_axi_wvalid_in)
        s_axi_wready_out <= 1'b1;
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_st_q <= edge_ctl_pkg::WR_IDLE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end
    else
    begin
      case (wr_st_q)
        edge_ctl_pkg::WR_IDLE:
        begin
          if (wr_fire)
          begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            wr_st_q <= edge_ctl_pkg::WR_RESP;
          end
        end
        default:
        begin
          if (s_axi_bready_in)
          begin
            s_axi_bvalid_out <= 1'b0;
            wr_st_q <= edge_ctl_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end

  // control registers written by software, lane 0 only
  logic wr_lane0;
  assign wr_lane0 = wr_fire & w_strb_q[0];
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      main_ctl_q <= `RST_BYTE;
      cur_ctl_q <= `RST_BYTE;
      irq_en_q <= 1'b0;
    end
    else if (wr_lane0)
    begin
      // unimplemented bit 6 stays zero
      if (aw_addr_q == `ADDR_MAIN_CONTROL)
        main_ctl_q <= w_data_q[7:0] & `MC_WRITE_MASK;
      else if (aw_addr_q == `ADDR_CURRENT_CTRL)
        cur_ctl_q <= w_data_q[7:0];
      else if (aw_addr_q == `ADDR_IRQ)
        irq_en_q <= w_data_q[`IRQ_EN_BIT];
    end
  end

  // edge config and flags; hardware set wins over software clear
  logic cfg_wr;
  assign cfg_wr = wr_lane0 & (aw_addr_q == `ADDR_EDGE_CONFIG);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cfg_q <= edge_ctl_pkg::edge_cfg_t'(`RST_BYTE);
    else
    begin
      if (cfg_wr)
        cfg_q <= edge_ctl_pkg::edge_cfg_t'(w_data_q[7:0]);
      // level checked every cycle, so a new matching config sets at once
      if (ch1_hit)
        cfg_q.ch1_flag <= 1'b1;
      if (ch2_hit)
        cfg_q.ch2_flag <= 1'b1;
    end
  end

  // interrupt flag on gate falling; set wins over software clear
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gate_prev_q <= 1'b0;
      irq_flag_q <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      gate_prev_q <= gate_now;
      if (gate_prev_q & ~gate_now)
        irq_flag_q <= 1'b1;
      else if (wr_lane0 & (aw_addr_q == `ADDR_IRQ) & ~w_data_q[`IRQ_FLAG_BIT])
        irq_flag_q <= 1'b0;
      irq_out <= irq_flag_q & irq_en_q;
    end
  end

  // conversion trigger: one pulse when the second flag completes the pair
  logic both_now;
  assign both_now = cfg_q.ch1_flag & cfg_q.ch2_flag;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      both_prev_q <= 1'b0;
      conv_trigger_out <= 1'b0;
    end
    else
    begin
      both_prev_q <= both_now;
      conv_trigger_out <= main_ctl_q[`MC_TRIG_EN] & running &
                          both_now & ~both_prev_q;
    end
  end

  // analog outputs registered
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      analog_out <= '0;
    else
    begin
      analog_out.range <= cur_ctl_q[`CC_RANGE_HI:`CC_RANGE_LO];
      analog_out.trim <= cur_ctl_q[`CC_TRIM_HI:`CC_TRIM_LO];
      analog_out.discharge <= main_ctl_q[`MC_DISCHARGE];
      analog_out.delay_mode <= main_ctl_q[`MC_DELAY_MODE];
      // in delay mode the comparator may end the gate early
      analog_out.gate <= gate_now &
                         (~main_ctl_q[`MC_DELAY_MODE] | ~trip_s);
    end
  end

  // read channel, one read at a time
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rvalid_out & s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
      else if (s_axi_arvalid_in & s_axi_arready_out)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= `RESP_OKAY;
        s_axi_rdata_out <= '0;
        if (s_axi_araddr_in == `ADDR_MAIN_CONTROL)
          s_axi_rdata_out[7:0] <= main_ctl_q;
        else if (s_axi_araddr_in == `ADDR_EDGE_CONFIG)
          s_axi_rdata_out[7:0] <= cfg_q;
        else if (s_axi_araddr_in == `ADDR_CURRENT_CTRL)
          s_axi_rdata_out[7:0] <= cur_ctl_q;
        else if (s_axi_araddr_in == `ADDR_IRQ)
          s_axi_rdata_out[1:0] <= {irq_en_q, irq_flag_q};
        else
          s_axi_rresp_out <= `RESP_SLVERR;
      end
      else if (s_axi_arvalid_in & ~s_axi_rvalid_out)
        s_axi_arready_out <= 1'b1;
    end
  end

  // checks
  AST_GATE_ONE_FLAG: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    analog_out.gate |-> $past(cfg_q.ch1_flag ^ cfg_q.ch2_flag))
    else $error("gate high without exactly one flag");
  AST_BLOCKED_NO_SET: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (!main_ctl_q[`MC_EDGE_PASS] && !cfg_wr && !cfg_q.ch1_flag) |=> !cfg_q.ch1_flag)
    else $error("flag set while edges blocked");
  AST_LEVEL_SETS: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ch1_hit |=> cfg_q.ch1_flag)
    else $error("channel one response did not set flag");
  AST_ORDERED: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (main_ctl_q[`MC_ORDERED] && !cfg_q.ch1_flag && !cfg_q.ch2_flag && !cfg_wr)
    |=> !cfg_q.ch2_flag)
    else $error("channel two set before channel one");
  AST_IRQ_SET: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (gate_prev_q && !gate_now) |=> irq_flag_q ##1 (irq_out == $past(irq_en_q)))
    else $error("interrupt flag missed gate off");
  AST_TRIG_OFF: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    conv_trigger_out |-> $past(main_ctl_q[`MC_TRIG_EN]) ##1 !conv_trigger_out)
    else $error("trigger without enable or too long");
  AST_DISCHARGE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    main_ctl_q[`MC_DISCHARGE] [*2] |-> analog_out.discharge)
    else $error("discharge output not following control");
  AST_DISABLED: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !main_ctl_q[`MC_MODULE_EN] [*2] |-> !analog_out.gate)
    else $error("gate while module disabled");
  AST_IDLE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (main_ctl_q[`MC_IDLE_STOP] && idle_s) |-> !ch1_hit && !ch2_hit)
    else $error("response during idle stop");
  AST_DELAY_CUT: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (main_ctl_q[`MC_DELAY_MODE] && trip_s) |=> !analog_out.gate)
    else $error("delay pulse outlived comparator trip");
endmodule : edge_ctl

// *** testbench/far_side_model.sv ***
// far side model: charge node, comparator and converter start counter
// assumes gate and discharge arrive as registered levels
`timescale 1ns/1ps
module far_side_model #(
  parameter int TRIP = 20
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // controls from the block
  input wire logic gate_in,
  input wire logic discharge_in,
  input wire logic trigger_in,
  // answers
  output logic trip_out,
  output int conv_count_out
);
  int charge_q; // charge on the node, in cycles
  // node charges while gated, shorted by discharge
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in) charge_q <= 0;
    else if (discharge_in) charge_q <= 0;
    else if (gate_in && charge_q < TRIP) charge_q <= charge_q + 1;
  end
  // comparator stays tripped until the node is drained
  assign trip_out = (charge_q >= TRIP);
  // one conversion per trigger pulse
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in) conv_count_out <= 0;
    else if (trigger_in) conv_count_out <= conv_count_out + 1;
  end
endmodule : far_side_model

// *** testbench/tb.sv ***
// self-checking bench of the edge control block
// assumes the far side model drives the comparator level
`timescale 1ns/1ps
`include "edge_ctl_map.svh"
module tb;
  logic clk, nrst; // clock, reset
  logic [3:0] awaddr, araddr; // addresses
  logic awv, wv, bready, arv, rready; // master strobes
  logic awr, wr_rdy, bv, arr, rv; // slave answers
  logic [31:0] wdata, rdata; // data
  logic [1:0] bresp, rresp; // responses
  logic [3:0] strb; // write strobes
  logic [1:0] eresp; // expected response code
  logic [3:0] src; // pin a, pin b, cmp a, cmp b
  logic idle, trip, trig, irq; // misc pins
  edge_ctl_pkg::analog_ctl_t ana; // analog side
  int err_count, check_count, cyc, convs, seed; // bookkeeping
  logic [7:0] v, cfg; // scratch
  logic [1:0] c; // source code
  logic [7:0] corner [4] = '{8'h7C, 8'h87, 8'h02, 8'h01}; // trim/range ends
  logic [7:0] offs [3] = '{8'h08, 8'h80, 8'hA8}; // blocked modes

  edge_ctl i_edge_ctl (.ref_clk_in(clk), .nrst_in(nrst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
    .ext_edge_pin_a_in(src[3]), .ext_edge_pin_b_in(src[2]),
    .compare_unit_a_in(src[1]), .compare_unit_b_in(src[0]),
    .chip_idle_in(idle), .comparator_trip_in(trip),
    .analog_out(ana), .conv_trigger_out(trig), .irq_out(irq));

  far_side_model i_far_side_model (.clk_in(clk), .nrst_in(nrst),
    .gate_in(ana.gate), .discharge_in(ana.discharge), .trigger_in(trig),
    .trip_out(trip), .conv_count_out(convs));

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end
    while (!bv);
    bready <= 1'b0;
    chk("bresp", eresp, bresp);
    tick(3);
  endtask : wr

  // read and compare one register
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rready <= 1'b0;
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", eresp, rresp);
    @(posedge clk);
  endtask : rd

  initial
  begin
    seed = 2510;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    {nrst, awv, wv, bready, arv, rready, idle} = '0;
    {awaddr, araddr, wdata, src} = '0;
    strb = 4'hF;
    eresp = `RESP_OKAY;
    tick(5);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 8'h00);
    eresp = `RESP_SLVERR;
    wr(4'h2, 8'hFF); // unmapped
    rd(4'h2, 8'h00); // unmapped
    eresp = `RESP_OKAY;
    $display("done: reset values");
    // range and trim, corners then random
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 4) ? corner[i] : 8'($random(seed));
      wr(`ADDR_CURRENT_CTRL, v);
      chk("range", v[1:0], ana.range);
      chk("trim", v[7:2], ana.trim);
      rd(`ADDR_CURRENT_CTRL, v);
    end
    strb <= 4'h0;
    wr(`ADDR_CURRENT_CTRL, ~v); // lane 0 off, no effect
    strb <= 4'hF;
    rd(`ADDR_CURRENT_CTRL, v);
    $display("done: current control");
    wr(`ADDR_EDGE_CONFIG, 8'h01);
    chk("gate off", 1'b0, ana.gate);
    wr(`ADDR_MAIN_CONTROL, 8'hC0);
    rd(`ADDR_MAIN_CONTROL, 8'h80);
    // software flag writes, edges blocked
    for (int f = 0; f < 4; f++)
    begin
      wr(`ADDR_EDGE_CONFIG, 8'(f));
      chk("gate sw", ^f[1:0], ana.gate);
    end
    wr(`ADDR_EDGE_CONFIG, 8'h00);
    chk("gate clr", 1'b0, ana.gate);
    $display("done: software flags");
    wr(`ADDR_IRQ, 8'h02);
    // one measurement per source code, second event on another code
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      cfg = {1'b1, c ^ 2'h1, 1'b1, c, 2'b00};
      src <= 4'h0;
      wr(`ADDR_MAIN_CONTROL, 8'h80);
      wr(`ADDR_EDGE_CONFIG, cfg);
      wr(`ADDR_MAIN_CONTROL, 8'h89);
      chk("gate idle", 1'b0, ana.gate);
      src[c] <= 1'b1;
      tick(6);
      chk("gate on", 1'b1, ana.gate);
      rd(`ADDR_EDGE_CONFIG, cfg | 8'h01);
      src[c] <= 1'b0;
      src[c ^ 2'h1] <= 1'b1;
      tick(6);
      chk("gate end", 1'b0, ana.gate);
      rd(`ADDR_EDGE_CONFIG, cfg | 8'h03);
    end
    chk("triggers", 4, convs);
    chk("irq", 1'b1, irq);
    rd(`ADDR_IRQ, 8'h03);
    wr(`ADDR_IRQ, 8'h02);
    chk("irq clr", 1'b0, irq);
    $display("done: edge sources");
    // config change matching the present level
    src <= 4'h0;
    wr(`ADDR_MAIN_CONTROL, 8'h80);
    wr(`ADDR_EDGE_CONFIG, 8'hDC);
    wr(`ADDR_MAIN_CONTROL, 8'h88);
    wr(`ADDR_EDGE_CONFIG, 8'hCC);
    rd(`ADDR_EDGE_CONFIG, 8'hCD);
    // ordered edges, channel two first, interrupt masked
    wr(`ADDR_MAIN_CONTROL, 8'h80);
    wr(`ADDR_EDGE_CONFIG, 8'hDC);
    wr(`ADDR_IRQ, 8'h00);
    wr(`ADDR_MAIN_CONTROL, 8'h8C);
    src[2] <= 1'b1;
    tick(6);
    rd(`ADDR_EDGE_CONFIG, 8'hDC);
    src[3] <= 1'b1;
    tick(6);
    rd(`ADDR_EDGE_CONFIG, 8'hDF);
    chk("irq masked", 1'b0, irq);
    rd(`ADDR_IRQ, 8'h01);
    chk("no trigger", 4, convs);
    $display("done: ordered edges");
    // module off, edges blocked, idle stop
    for (int i = 0; i < 3; i++)
    begin
      src <= 4'h0;
      wr(`ADDR_MAIN_CONTROL, 8'h80);
      wr(`ADDR_EDGE_CONFIG, 8'hDC);
      wr(`ADDR_MAIN_CONTROL, offs[i]);
      idle <= (i == 2);
      src <= 4'hC;
      tick(6);
      rd(`ADDR_EDGE_CONFIG, 8'hDC);
      chk("gate held", 1'b0, ana.gate);
    end
    idle <= 1'b0;
    src <= 4'h0;
    $display("done: blocked modes");
    // delay mode ends the pulse at the comparator
    wr(`ADDR_MAIN_CONTROL, 8'h80);
    wr(`ADDR_EDGE_CONFIG, 8'hDC);
    wr(`ADDR_MAIN_CONTROL, 8'h92);
    chk("discharge", 1'b1, ana.discharge);
    chk("delay mode", 1'b1, ana.delay_mode);
    wr(`ADDR_MAIN_CONTROL, 8'h90);
    chk("discharge off", 1'b0, ana.discharge);
    wr(`ADDR_EDGE_CONFIG, 8'hDD);
    chk("pulse on", 1'b1, ana.gate);
    tick(30);
    chk("pulse end", 1'b0, ana.gate);
    rd(`ADDR_EDGE_CONFIG, 8'hDD);
    wr(`ADDR_MAIN_CONTROL, 8'h80);
    chk("measure mode", 1'b0, ana.delay_mode);
    $display("done: delay mode");
    summarize();
  end
endmodule : tb
